// ===== rtl/wtmc_pkg.sv
package wtmc_pkg;
    // Clock rate of clock_in
    localparam int unsigned CLK_HZ = 20_000_000;
    // Wake-up base steps, in milliseconds
    localparam int unsigned BASE_LONG_MS = 100;
    localparam int unsigned BASE_SHORT_MS = 10;
    // The timer ticks in short steps; the long range is a multiple of them
    localparam int unsigned STEP_CYCLES = CLK_HZ / 1000 * BASE_SHORT_MS;
    localparam logic [6:0] LONG_MULT = 7'(BASE_LONG_MS / BASE_SHORT_MS);
    localparam logic [6:0] SHORT_MULT = 7'H01;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_RSVD_A = 6'H2F;
    localparam logic [5:0] IDX_AUX_STATUS = 6'H30;
    localparam logic [5:0] IDX_WAKEUP_CTRL = 6'H31;
    localparam logic [5:0] IDX_AMP_CONFIG = 6'H32;
    localparam logic [5:0] IDX_AMP_REF = 6'H33;
    localparam logic [5:0] IDX_AMP_AVG = 6'H34;
    localparam logic [5:0] IDX_AMP_LAST = 6'H35;
    localparam logic [5:0] IDX_PH_CONFIG = 6'H36;
    localparam logic [5:0] IDX_PH_REF = 6'H37;
    localparam logic [5:0] IDX_PH_AVG = 6'H38;
    localparam logic [5:0] IDX_PH_LAST = 6'H39;

    // Wake-up control fields
    localparam int unsigned WU_RANGE_BIT = 7;
    localparam int unsigned WU_CODE_MSB = 6;
    localparam int unsigned WU_CODE_LSB = 4;
    localparam int unsigned WU_EVERY_BIT = 3;
    localparam int unsigned WU_AMP_BIT = 2;
    localparam int unsigned WU_PH_BIT = 1;
    localparam logic [7:0] WU_WRITE_MASK = 8'HFE;

    // Measurement configuration fields
    localparam int unsigned CFG_DELTA_MSB = 7;
    localparam int unsigned CFG_DELTA_LSB = 4;
    localparam int unsigned CFG_INCL_BIT = 3;
    localparam int unsigned CFG_WGT_MSB = 2;
    localparam int unsigned CFG_WGT_LSB = 1;
    localparam int unsigned CFG_REFSEL_BIT = 0;
    // Weight code 00 means divide by 4, i.e. shift by 2
    localparam logic [2:0] WGT_SHIFT_BASE = 3'H2;

    // Reset value of every register
    localparam logic [7:0] REG_RESET = 8'H00;
endpackage

// ===== rtl/wtmc_wakeup_timer.sv
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module wtmc_wakeup_timer
    import wtmc_pkg::*;
#(
    parameter int unsigned P_STEP_CYCLES = STEP_CYCLES
) (
    // Clock, reset, enable
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Restore-defaults command, one-cycle pulse
    input wire logic set_default_in,
    // Measurement engine handshake
    output logic meas_start_out,
    output logic meas_phase_out,
    input wire logic meas_done_in,
    input wire logic [7:0] meas_result_in,
    // Interrupt request pulses
    output logic irq_timeout_out,
    output logic irq_amplitude_out,
    output logic irq_phase_out,
    // Status sources
    input wire logic rx_channel_phase_in,
    input wire logic ext_field_in,
    input wire logic tx_active_in,
    input wire logic osc_stable_in,
    input wire logic rx_enabled_in,
    input wire logic rx_busy_in,
    input wire logic peer_detect_in,
    input wire logic collision_avoid_active_in
);

    // Sequencer states
    typedef enum logic [2:0] {
        S_IDLE = 3'H1,
        S_AMP = 3'H2,
        S_PH = 3'H4
    } wtmc_state_e;
    // Absolute difference of two bytes
    function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
        abs_diff = (a > b) ? (a - b) : (b - a);
    endfunction
    // Running average step: avg + (new - avg) / weight
    function automatic logic [7:0] avg_step(input logic [7:0] avg, input logic [7:0] res,
                                            input logic [1:0] wcode);
        logic signed [9:0] diff;
        logic signed [9:0] step;
        logic [2:0] sh;
        logic [9:0] sum;
        diff = $signed({2'H0, res}) - $signed({2'H0, avg});
        sh = WGT_SHIFT_BASE + {1'H0, wcode};
        step = diff >>> sh;
        sum = 10'({2'H0, avg}) + 10'(step);
        avg_step = sum[7:0];
    endfunction
    // Step count of one wake-up period
    function automatic logic [6:0] period_steps(input logic [7:0] ctrl);
        logic [6:0] mult;
        logic [6:0] code1;
        mult = ctrl[WU_RANGE_BIT] ? SHORT_MULT : LONG_MULT;
        code1 = 7'(ctrl[WU_CODE_MSB:WU_CODE_LSB]) + 7'H01;
        period_steps = 7'(code1 * mult);
    endfunction
    // Registers visible to software
    logic [7:0] wu_ctrl_ff;
    logic [7:0] amp_cfg_ff;
    logic [7:0] amp_ref_ff;
    logic [7:0] amp_avg_ff;
    logic [7:0] amp_last_ff;
    logic [7:0] ph_cfg_ff;
    logic [7:0] ph_ref_ff;
    logic [7:0] ph_avg_ff;
    logic [7:0] ph_last_ff;
    // Synchronisers for the two asynchronous status pins
    logic efd_meta_ff;
    logic efd_ff;
    logic osc_meta_ff;
    logic osc_ff;
    // Timer state
    logic [31:0] tick_cnt_ff;
    logic [6:0] step_cnt_ff;
    logic timeout;
    logic timer_run;
    // Sequencer
    wtmc_state_e state_ff;
    wtmc_state_e nxt_state;
    // Bus outputs
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    // Pulse outputs and the measurement channel level
    logic meas_start_ff;
    logic meas_phase_ff;
    logic irq_to_ff;
    logic irq_amp_ff;
    logic irq_ph_ff;
    // Decoded bus access
    logic [5:0] idx;
    logic addr_ok;
    logic wr_en;
    logic setup;
    logic [7:0] aux_status;
    logic [7:0] rd_byte;
    // Measurement evaluation
    logic [7:0] amp_baseline;
    logic [7:0] ph_baseline;
    logic amp_trig;
    logic ph_trig;
    logic amp_done;
    logic ph_done;
    assign idx = paddr_in[7:2];
    assign setup = psel_in && !penable_in;
    assign wr_en = psel_in && penable_in && pwrite_in && addr_ok && ce_in;
    // Zero-wait slave: data is fetched in the setup cycle
    assign pready_out = 1'H1;
    assign prdata_out = prdata_ff;
    assign pslverr_out = pslverr_ff;
    assign meas_start_out = meas_start_ff;
    assign meas_phase_out = meas_phase_ff;
    assign irq_timeout_out = irq_to_ff;
    assign irq_amplitude_out = irq_amp_ff;
    assign irq_phase_out = irq_ph_ff;
    // Two-stage synchronisers; nothing else reads the first stage
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            efd_meta_ff <= 1'H0;
            efd_ff <= 1'H0;
            osc_meta_ff <= 1'H0;
            osc_ff <= 1'H0;
        end else if (ce_in) begin
            efd_meta_ff <= ext_field_in;
            efd_ff <= efd_meta_ff;
            osc_meta_ff <= osc_stable_in;
            osc_ff <= osc_meta_ff;
        end
    end
    // Live status, stored only in the bit 6 and bit 4 synchronisers; bit 7 first, bit 0 last
    assign aux_status = {rx_channel_phase_in, efd_ff, tx_active_in, osc_ff,
                         rx_enabled_in, rx_busy_in, peer_detect_in, collision_avoid_active_in};
    // Read decode; the reserved slot reads zero without error
    always_comb begin
        rd_byte = 8'H00;
        addr_ok = 1'H1;
        unique case (idx)
            IDX_RSVD_A: rd_byte = 8'H00;
            IDX_AUX_STATUS: rd_byte = aux_status;
            IDX_WAKEUP_CTRL: rd_byte = wu_ctrl_ff;
            IDX_AMP_CONFIG: rd_byte = amp_cfg_ff;
            IDX_AMP_REF: rd_byte = amp_ref_ff;
            IDX_AMP_AVG: rd_byte = amp_avg_ff;
            IDX_AMP_LAST: rd_byte = amp_last_ff;
            IDX_PH_CONFIG: rd_byte = ph_cfg_ff;
            IDX_PH_REF: rd_byte = ph_ref_ff;
            IDX_PH_AVG: rd_byte = ph_avg_ff;
            IDX_PH_LAST: rd_byte = ph_last_ff;
            default: addr_ok = 1'H0;
        endcase
    end
    // Read data and error are latched in setup and held for the access cycle
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prdata_ff <= 32'H0000_0000;
            pslverr_ff <= 1'H0;
        end else if (ce_in && setup) begin
            prdata_ff <= {24'H00_0000, rd_byte};
            pslverr_ff <= !addr_ok;
        end
    end
    // Software registers; writes to read-only slots are dropped silently
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wu_ctrl_ff <= REG_RESET;
            amp_cfg_ff <= REG_RESET;
            amp_ref_ff <= REG_RESET;
            ph_cfg_ff <= REG_RESET;
            ph_ref_ff <= REG_RESET;
        end else if (ce_in) begin
            if (set_default_in) begin
                wu_ctrl_ff <= REG_RESET;
                amp_cfg_ff <= REG_RESET;
                amp_ref_ff <= REG_RESET;
                ph_cfg_ff <= REG_RESET;
                ph_ref_ff <= REG_RESET;
            end else if (wr_en) begin
                unique case (idx)
                    // Bit 0 of control is reserved and stays zero
                    IDX_WAKEUP_CTRL: wu_ctrl_ff <= pwdata_in[7:0] & WU_WRITE_MASK;
                    IDX_AMP_CONFIG: amp_cfg_ff <= pwdata_in[7:0];
                    IDX_AMP_REF: amp_ref_ff <= pwdata_in[7:0];
                    IDX_PH_CONFIG: ph_cfg_ff <= pwdata_in[7:0];
                    IDX_PH_REF: ph_ref_ff <= pwdata_in[7:0];
                    default: ;
                endcase
            end
        end
    end
    // The timer runs only while some wake-up action is enabled
    assign timer_run = wu_ctrl_ff[WU_EVERY_BIT] || wu_ctrl_ff[WU_AMP_BIT] || wu_ctrl_ff[WU_PH_BIT];
    assign timeout = timer_run && (tick_cnt_ff == P_STEP_CYCLES - 1)
                     && (step_cnt_ff == period_steps(wu_ctrl_ff) - 7'H01);
    // Step prescaler and step counter; a control write restarts the period
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tick_cnt_ff <= 32'H0000_0000;
            step_cnt_ff <= 7'H00;
        end else if (ce_in) begin
            if (!timer_run || set_default_in || (wr_en && idx == IDX_WAKEUP_CTRL)) begin
                tick_cnt_ff <= 32'H0000_0000;
                step_cnt_ff <= 7'H00;
            end else if (tick_cnt_ff == P_STEP_CYCLES - 1) begin
                tick_cnt_ff <= 32'H0000_0000;
                // Wrap at the period end; a shortened code also wraps
                if (timeout || step_cnt_ff >= period_steps(wu_ctrl_ff) - 7'H01) begin
                    step_cnt_ff <= 7'H00;
                end else begin
                    step_cnt_ff <= step_cnt_ff + 7'H01;
                end
            end else begin
                tick_cnt_ff <= tick_cnt_ff + 32'H0000_0001;
            end
        end
    end
    // Compare each result against the chosen baseline
    always_comb begin
        amp_baseline = amp_cfg_ff[CFG_REFSEL_BIT] ? amp_avg_ff : amp_ref_ff;
        ph_baseline = ph_cfg_ff[CFG_REFSEL_BIT] ? ph_avg_ff : ph_ref_ff;
        // Strictly larger than the delta triggers
        amp_trig = abs_diff(meas_result_in, amp_baseline) > 8'(amp_cfg_ff[CFG_DELTA_MSB:CFG_DELTA_LSB]);
        ph_trig = abs_diff(meas_result_in, ph_baseline) > 8'(ph_cfg_ff[CFG_DELTA_MSB:CFG_DELTA_LSB]);
        amp_done = (state_ff == S_AMP) && meas_done_in;
        ph_done = (state_ff == S_PH) && meas_done_in;
    end
    // Sequencer: amplitude first, then phase, at each timeout
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            S_IDLE: begin
                if (timeout && wu_ctrl_ff[WU_AMP_BIT]) begin
                    nxt_state = S_AMP;
                end else if (timeout && wu_ctrl_ff[WU_PH_BIT]) begin
                    nxt_state = S_PH;
                end
            end
            S_AMP: begin
                if (meas_done_in) begin
                    nxt_state = wu_ctrl_ff[WU_PH_BIT] ? S_PH : S_IDLE;
                end
            end
            S_PH: begin
                if (meas_done_in) begin
                    nxt_state = S_IDLE;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
    end
    // State register; restore-defaults abandons a measurement in flight
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= S_IDLE;
        end else if (ce_in) begin
            state_ff <= set_default_in ? S_IDLE : nxt_state;
        end
    end
    // Start pulse and channel for the measurement engine
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meas_start_ff <= 1'H0;
            meas_phase_ff <= 1'H0;
        end else if (ce_in) begin
            meas_start_ff <= !set_default_in && (nxt_state != state_ff) && (nxt_state != S_IDLE);
            if (nxt_state == S_PH) begin
                meas_phase_ff <= 1'H1;
            end else if (nxt_state == S_AMP) begin
                meas_phase_ff <= 1'H0;
            end
        end
    end

    // Interrupt pulses, one cycle each
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_to_ff <= 1'H0;
            irq_amp_ff <= 1'H0;
            irq_ph_ff <= 1'H0;
        end else if (ce_in) begin
            irq_to_ff <= timeout && wu_ctrl_ff[WU_EVERY_BIT] && !set_default_in;
            irq_amp_ff <= amp_done && amp_trig && !set_default_in;
            irq_ph_ff <= ph_done && ph_trig && !set_default_in;
        end
    end

    // Amplitude result and running average
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            amp_last_ff <= REG_RESET;
            amp_avg_ff <= REG_RESET;
        end else if (ce_in) begin
            if (set_default_in) begin
                amp_last_ff <= REG_RESET;
                amp_avg_ff <= REG_RESET;
            end else if (amp_done) begin
                amp_last_ff <= meas_result_in;
                // A triggering result is folded in only when allowed
                if (!amp_trig || amp_cfg_ff[CFG_INCL_BIT]) begin
                    amp_avg_ff <= avg_step(amp_avg_ff, meas_result_in,
                                           amp_cfg_ff[CFG_WGT_MSB:CFG_WGT_LSB]);
                end
            end
        end
    end

    // Phase result and running average
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ph_last_ff <= REG_RESET;
            ph_avg_ff <= REG_RESET;
        end else if (ce_in) begin
            if (set_default_in) begin
                ph_last_ff <= REG_RESET;
                ph_avg_ff <= REG_RESET;
            end else if (ph_done) begin
                ph_last_ff <= meas_result_in;
                if (!ph_trig || ph_cfg_ff[CFG_INCL_BIT]) begin
                    ph_avg_ff <= avg_step(ph_avg_ff, meas_result_in,
                                          ph_cfg_ff[CFG_WGT_MSB:CFG_WGT_LSB]);
                end
            end
        end
    end

endmodule

`default_nettype wire

// ===== bench/wtmc_props.sv
`timescale 1ns/1ps
`default_nettype none
module wtmc_props
    import wtmc_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    // APB side
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] prdata_out,
    // Measurement handshake and requests
    input wire logic meas_start_out,
    input wire logic meas_phase_out,
    input wire logic meas_done_in,
    input wire logic irq_timeout_out,
    input wire logic irq_amplitude_out,
    input wire logic irq_phase_out,
    // Same-clock status sources
    input wire logic rx_channel_phase_in,
    input wire logic tx_active_in,
    input wire logic rx_enabled_in,
    input wire logic rx_busy_in,
    input wire logic peer_detect_in,
    input wire logic collision_avoid_active_in
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    // Status read in its access cycle; data was captured at the setup edge
    wire logic stat_rd = psel_in && penable_in && !pwrite_in && paddr_in[7:2] == IDX_AUX_STATUS;
    property p_tmo_pulse;
        irq_timeout_out && ce_in |=> !irq_timeout_out;
    endproperty
    a_tmo_pulse: assert property (p_tmo_pulse) else $error("timeout request held too long");
    property p_start_pulse;
        meas_start_out && ce_in && !meas_done_in |=> !meas_start_out;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start held too long");
    property p_amp_irq;
        irq_amplitude_out && $past(ce_in) |-> $past(meas_done_in) && !$past(meas_phase_out);
    endproperty
    a_amp_irq: assert property (p_amp_irq) else $error("amplitude request without result");
    property p_ph_irq;
        irq_phase_out && $past(ce_in) |-> $past(meas_done_in) && $past(meas_phase_out);
    endproperty
    a_ph_irq: assert property (p_ph_irq) else $error("phase request without result");
    property p_stat_chan;
        stat_rd && $past(ce_in) |-> prdata_out[7] == $past(rx_channel_phase_in);
    endproperty
    a_stat_chan: assert property (p_stat_chan) else $error("channel bit wrong");
    property p_stat_tx;
        stat_rd && $past(ce_in) |-> prdata_out[5] == $past(tx_active_in);
    endproperty
    a_stat_tx: assert property (p_stat_tx) else $error("transmit bit wrong");
    property p_stat_rx;
        stat_rd && $past(ce_in) |-> prdata_out[3:2] == {$past(rx_enabled_in), $past(rx_busy_in)};
    endproperty
    a_stat_rx: assert property (p_stat_rx) else $error("receive bits wrong");
    property p_stat_peer;
        stat_rd && $past(ce_in) |-> prdata_out[1:0] == {$past(peer_detect_in), $past(collision_avoid_active_in)};
    endproperty
    a_stat_peer: assert property (p_stat_peer) else $error("detector mode bits wrong");
    property p_upper_zero;
        psel_in && penable_in |-> prdata_out[31:8] == 24'H000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("read data above byte not zero");
endmodule
bind wtmc_wakeup_timer wtmc_props u_props (.clock_in(clock_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .prdata_out(prdata_out), .meas_start_out(meas_start_out), .meas_phase_out(meas_phase_out),
    .meas_done_in(meas_done_in), .irq_timeout_out(irq_timeout_out), .irq_amplitude_out(irq_amplitude_out),
    .irq_phase_out(irq_phase_out), .rx_channel_phase_in(rx_channel_phase_in), .tx_active_in(tx_active_in),
    .rx_enabled_in(rx_enabled_in), .rx_busy_in(rx_busy_in), .peer_detect_in(peer_detect_in),
    .collision_avoid_active_in(collision_avoid_active_in));
`default_nettype wire

// ===== bench/wtmc_wakeup_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wtmc_wakeup_timer_tb
    import wtmc_pkg::*;
();
    // Short step keeps the longest period at 800 cycles
    localparam int unsigned STEP = 10;
    localparam logic [2:0] CODES [3] = '{3'H0, 3'H3, 3'H7};
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic ce_in = 1'b1;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, meas_done_in = 1'b0, set_default_in = 1'b0;
    logic [7:0] paddr_in = 8'H00, meas_result_in = 8'H00, stat = 8'H00, rd;
    logic [31:0] pwdata_in = 32'H00000000;
    logic err;
    wire logic [31:0] prdata_out;
    wire logic pready_out, pslverr_out, meas_start_out, meas_phase_out;
    wire logic irq_timeout_out, irq_amplitude_out, irq_phase_out;
    int num_errors = 0;
    int check_count = 0;
    int pause_n;

    always #25 clock_in = ~clock_in;

    wtmc_wakeup_timer #(.P_STEP_CYCLES(STEP)) DUT (.clock_in(clock_in), .resetn_in(resetn_in), .ce_in(ce_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .set_default_in(set_default_in), .meas_start_out(meas_start_out), .meas_phase_out(meas_phase_out),
        .meas_done_in(meas_done_in), .meas_result_in(meas_result_in), .irq_timeout_out(irq_timeout_out),
        .irq_amplitude_out(irq_amplitude_out), .irq_phase_out(irq_phase_out), .rx_channel_phase_in(stat[7]),
        .ext_field_in(stat[6]), .tx_active_in(stat[5]), .osc_stable_in(stat[4]), .rx_enabled_in(stat[3]),
        .rx_busy_in(stat[2]), .peer_detect_in(stat[1]), .collision_avoid_active_in(stat[0]));

    // Compare and count; four-state so unknowns never match
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // One APB transfer; starts after an edge so back-to-back calls never clash
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] r,
                       output logic e);
        @(posedge clock_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= {idx, 2'H0};
        pwdata_in <= {24'H000000, wd};
        @(posedge clock_in);
        penable_in <= 1'b1;
        // Ends at the first edge with pready_out high; the watchdog catches a hang
        do begin
            @(posedge clock_in);
        end while (pready_out !== 1'b1);
        r = prdata_out[7:0];
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, rd, err);
    endtask

    task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'H00, rd, err);
        chk(rd, exp);
    endtask

    // Restore-defaults pulse
    task automatic sdef();
        @(posedge clock_in);
        set_default_in <= 1'b1;
        @(posedge clock_in);
        set_default_in <= 1'b0;
    endtask

    // Status sources settle past the two-stage synchroniser before reading
    task automatic stat_chk(input logic [7:0] v);
        @(posedge clock_in);
        stat <= v;
        repeat (4) @(posedge clock_in);
        rdchk(IDX_AUX_STATUS, v);
    endtask

    // Time between two timeout requests equals one programmed period
    task automatic tper(input logic r, input logic [2:0] c);
        int n;
        int exp;
        exp = (c + 1) * (r ? SHORT_MULT : LONG_MULT) * STEP;
        wr(IDX_WAKEUP_CTRL, {r, c, 4'H8});
        for (n = 0; n < 3000 && irq_timeout_out !== 1'b1; n++) @(negedge clock_in);
        @(negedge clock_in);
        for (n = 1; n < 3000 && irq_timeout_out !== 1'b1; n++) @(negedge clock_in);
        chk(n, exp);
    endtask

    // Answer one measurement start; result line shows junk once released
    task automatic meas(input logic [7:0] res, input logic ph, input logic ia, input logic ip);
        while (meas_start_out !== 1'b1) @(negedge clock_in);
        chk(meas_phase_out, ph);
        repeat (2) @(posedge clock_in);
        meas_done_in <= 1'b1;
        meas_result_in <= res;
        @(posedge clock_in);
        meas_done_in <= 1'b0;
        meas_result_in <= ~res;
        @(negedge clock_in);
        chk({irq_amplitude_out, irq_phase_out}, {ia, ip});
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // A hang counts as a mismatch
    initial begin
        #1000000;
        num_errors++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge clock_in);
        resetn_in <= 1'b1;
        for (int i = 'H2F; i <= 'H39; i++) rdchk(6'(i), REG_RESET);
        wr(IDX_AMP_REF, 8'HA5);
        rdchk(IDX_AMP_REF, 8'HA5);
        wr(IDX_PH_REF, 8'H5A);
        rdchk(IDX_PH_REF, 8'H5A);
        wr(IDX_AMP_CONFIG, 8'HC7);
        rdchk(IDX_AMP_CONFIG, 8'HC7);
        wr(IDX_WAKEUP_CTRL, 8'H71);
        rdchk(IDX_WAKEUP_CTRL, 8'H70);
        wr(IDX_AMP_AVG, 8'HFF);
        rdchk(IDX_AMP_AVG, REG_RESET);
        // Unmapped index is refused
        apb(1'b0, 6'H3A, 8'H00, rd, err);
        chk(err, 1'b1);
        sdef();
        rdchk(IDX_AMP_REF, REG_RESET);
        rdchk(IDX_PH_REF, REG_RESET);
        rdchk(IDX_WAKEUP_CTRL, REG_RESET);
        stat_chk(8'HAA);
        stat_chk(8'H55);
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 3; k++) tper(r[0], CODES[k]);
        end
        // Enable low for 20 cycles freezes the timer; counting starts after the pause
        wr(IDX_WAKEUP_CTRL, 8'HB8);
        while (irq_timeout_out !== 1'b1) @(negedge clock_in);
        @(posedge clock_in);
        ce_in <= 1'b0;
        repeat (20) @(posedge clock_in);
        ce_in <= 1'b1;
        pause_n = 0;
        do begin
            @(negedge clock_in);
            pause_n++;
        end while (irq_timeout_out !== 1'b1);
        chk(pause_n, (3 + 1) * SHORT_MULT * STEP);
        // Register baseline, delta of 3, both sides of the reference
        wr(IDX_AMP_CONFIG, 8'H30);
        wr(IDX_AMP_REF, 8'H40);
        wr(IDX_WAKEUP_CTRL, 8'HF4);
        meas(8'H43, 1'b0, 1'b0, 1'b0);
        meas(8'H44, 1'b0, 1'b1, 1'b0);
        meas(8'H3C, 1'b0, 1'b1, 1'b0);
        wr(IDX_WAKEUP_CTRL, 8'H00);
        rdchk(IDX_AMP_LAST, 8'H3C);
        // Running average against every weight code, triggering result included
        for (int w = 0; w < 4; w++) begin
            sdef();
            wr(IDX_AMP_CONFIG, 8'HF9 | {5'H00, w[1:0], 1'b0});
            wr(IDX_WAKEUP_CTRL, 8'HF4);
            meas(8'H80, 1'b0, 1'b1, 1'b0);
            wr(IDX_WAKEUP_CTRL, 8'H00);
            rdchk(IDX_AMP_AVG, 8'H80 >> (2 + w));
        end
        // Average 04: up by 2, then down with floor
        wr(IDX_AMP_CONFIG, 8'HF9);
        wr(IDX_WAKEUP_CTRL, 8'HF4);
        meas(8'H0C, 1'b0, 1'b0, 1'b0);
        meas(8'H00, 1'b0, 1'b0, 1'b0);
        wr(IDX_WAKEUP_CTRL, 8'H00);
        rdchk(IDX_AMP_AVG, 8'H04);
        // Triggering result kept out of the average
        sdef();
        wr(IDX_AMP_CONFIG, 8'HF1);
        wr(IDX_WAKEUP_CTRL, 8'HF4);
        meas(8'H80, 1'b0, 1'b1, 1'b0);
        wr(IDX_WAKEUP_CTRL, 8'H00);
        rdchk(IDX_AMP_AVG, 8'H00);
        rdchk(IDX_AMP_LAST, 8'H80);
        // Both channels, amplitude first, then phase only
        sdef();
        wr(IDX_PH_REF, 8'H10);
        wr(IDX_WAKEUP_CTRL, 8'HF6);
        meas(8'H00, 1'b0, 1'b0, 1'b0);
        meas(8'H11, 1'b1, 1'b0, 1'b1);
        wr(IDX_WAKEUP_CTRL, 8'HF2);
        meas(8'H10, 1'b1, 1'b0, 1'b0);
        wr(IDX_WAKEUP_CTRL, 8'H00);
        rdchk(IDX_PH_LAST, 8'H10);
        rdchk(IDX_PH_AVG, 8'H04);
        summarize();
    end
endmodule
`default_nettype wire
